// ==== shared/plcr_pkg.sv ====
// Summary of operation
// - link status bits 15, 14, 13, 11 and 10 have no function and read zero.
// - link status bit 12, slot clock configuration, always reads one.
// - link status bits 9:4, negotiated width, read the constant 000001b.
// - link status bits 3:0 carry the negotiated speed from the link logic.
// - link status reads 101xh after reset, low bits following the speed.
// - device capabilities 2 bit 4 reads one: timeout disable is supported.
// - device capabilities 2 bits 3:0 read 0000b and bits 31:5 read zero.
// - device control 2 bit 4 is read/write and bits 3:0 read 0000b.
// - writable link control 2 fields survive link resets, cleared by global.
// - link control 2 bit 6 reads zero and ignores writes.
// - link control 2 bit 5 reads zero since autonomous speed is absent.
// - link status 2 is read-only, bit 0 the emphasis level, rest zero.
package plcr_pkg;
    // configuration byte offsets
    localparam logic [7:0] PLCR_OFF_LINK_STATE = 8'h82;
    localparam logic [7:0] PLCR_OFF_DEV_CAPS2 = 8'h94;
    localparam logic [7:0] PLCR_OFF_DEV_CTRL2 = 8'h98;
    localparam logic [7:0] PLCR_OFF_LINK_CTRL2 = 8'hA0;
    localparam logic [7:0] PLCR_OFF_LINK_STATE2 = 8'hA2;

    // speed encodings
    localparam logic [3:0] PLCR_SPEED_2G5 = 4'h1;
    localparam logic [3:0] PLCR_SPEED_5G = 4'h2;

    // link status fixed parts
    localparam logic [15:0] PLCR_LINK_STATE_FIXED = 16'h1010;
    localparam logic [5:0] PLCR_NEG_WIDTH_X1 = 6'h01;
    localparam int PLCR_SLOT_CLK_BIT = 12;

    // device capabilities 2
    localparam logic [31:0] PLCR_DEV_CAPS2_VAL = 32'h00000010;
    localparam logic [3:0] PLCR_TIMEOUT_RANGES = 4'h0;

    // device control 2
    localparam logic [15:0] PLCR_DEV_CTRL2_FIXED = 16'h0800;
    localparam logic [3:0] PLCR_TIMEOUT_VALUE = 4'h0;
    localparam int PLCR_TO_DIS_BIT = 4;
    localparam logic PLCR_TO_DIS_RST = 1'h0;

    // link control 2 field positions and writable mask
    localparam int PLCR_LC2_COMP_EMPH = 12;
    localparam int PLCR_LC2_COMP_SOS = 11;
    localparam int PLCR_LC2_MOD_COMP = 10;
    localparam int PLCR_LC2_MARGIN_HI = 9;
    localparam int PLCR_LC2_MARGIN_LO = 7;
    localparam int PLCR_LC2_SEL_EMPH = 6;
    localparam int PLCR_LC2_AUTO_OFF = 5;
    localparam int PLCR_LC2_COMP_ENTRY = 4;
    localparam logic [15:0] PLCR_LC2_WMASK = 16'h1F9F;
    localparam logic [15:0] PLCR_LC2_RST = 16'h0000;

    localparam logic [31:0] PLCR_UNMAPPED = 32'h00000000;
endpackage

// ==== logic/plcr_sync2.sv ====
`timescale 1ns/1ps
module plcr_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // level crossing
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] hold_reg;
    logic [W-1:0] hold_next;

    always_comb begin
        meta_next = async_in;
        hold_next = meta_reg;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RST;
            hold_reg <= RST;
        end else begin
            meta_reg <= meta_next;
            hold_reg <= hold_next;
        end
    end

    assign sync_out = hold_reg;
endmodule

// ==== logic/plcr_regs.sv ====
`timescale 1ns/1ps
module plcr_regs
    import plcr_pkg::*;
(
    // clock and global or power-on reset
    input wire logic mclk,
    input wire logic resetn,
    // ordinary link reset pin, active low
    input wire logic link_reset_n,
    // configuration access, dword aligned
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // status from the link logic
    input wire logic [3:0] current_speed,
    input wire logic emphasis_level_now,
    // controls toward the link logic
    output logic timeout_disable,
    output logic compliance_emphasis,
    output logic compliance_skip_ordered_set,
    output logic modified_compliance_entry,
    output logic [2:0] transmit_margin,
    output logic compliance_entry,
    output logic [3:0] target_speed
);
    logic [3:0] speed_sync;
    logic emph_sync;
    logic link_rst_sync_n;

    plcr_sync2 #(.W(4), .RST(PLCR_SPEED_2G5)) u_speed_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(current_speed),
        .sync_out(speed_sync)
    );

    plcr_sync2 #(.W(1), .RST(1'h0)) u_emph_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(emphasis_level_now),
        .sync_out(emph_sync)
    );

    plcr_sync2 #(.W(1), .RST(1'h1)) u_lrst_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(link_reset_n),
        .sync_out(link_rst_sync_n)
    );

    function automatic logic [5:0] dword_of(input logic [7:0] a);
        dword_of = a[7:2];
    endfunction

    // live status, sampled once more so reads see a stable copy
    logic [3:0] speed_reg;
    logic [3:0] speed_next;
    logic emph_reg;
    logic emph_next;

    always_comb begin
        speed_next = speed_sync;
        emph_next = emph_sync;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            speed_reg <= PLCR_SPEED_2G5;
            emph_reg <= 1'h0;
        end else begin
            speed_reg <= speed_next;
            emph_reg <= emph_next;
        end
    end

    // read images
    logic [15:0] link_state_report;
    logic [31:0] device_caps_second;
    logic [15:0] device_control_second;
    logic [15:0] link_control_second;
    logic [15:0] link_state_report_second;

    // writable storage
    logic to_dis_reg;
    logic to_dis_next;
    logic [15:0] lc2_reg;
    logic [15:0] lc2_next;

    always_comb begin
        link_state_report = PLCR_LINK_STATE_FIXED;
        link_state_report[PLCR_SLOT_CLK_BIT] = 1'h1;
        link_state_report[9:4] = PLCR_NEG_WIDTH_X1;
        link_state_report[3:0] = speed_reg;
        device_caps_second = PLCR_DEV_CAPS2_VAL;
        device_caps_second[3:0] = PLCR_TIMEOUT_RANGES;
        device_control_second = PLCR_DEV_CTRL2_FIXED;
        device_control_second[3:0] = PLCR_TIMEOUT_VALUE;
        device_control_second[PLCR_TO_DIS_BIT] = to_dis_reg;
        link_control_second = lc2_reg & PLCR_LC2_WMASK;
        link_state_report_second = {15'h0000, emph_reg};
    end

    logic wr_devctl;
    logic wr_lc2;

    always_comb begin
        wr_devctl = cfg_wr &&
                    dword_of(cfg_addr) == dword_of(PLCR_OFF_DEV_CTRL2);
        wr_lc2 = cfg_wr && dword_of(cfg_addr) == dword_of(PLCR_OFF_LINK_CTRL2);
        to_dis_next = to_dis_reg;
        if (!link_rst_sync_n) begin
            to_dis_next = PLCR_TO_DIS_RST;
        end else if (wr_devctl && cfg_be[0]) begin
            to_dis_next = cfg_wdata[PLCR_TO_DIS_BIT];
        end
        // link reset deliberately left out: these fields are sticky
        lc2_next = lc2_reg;
        if (wr_lc2 && cfg_be[0]) begin
            lc2_next[7:0] = cfg_wdata[7:0] & PLCR_LC2_WMASK[7:0];
        end
        if (wr_lc2 && cfg_be[1]) begin
            lc2_next[15:8] = cfg_wdata[15:8] & PLCR_LC2_WMASK[15:8];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            to_dis_reg <= PLCR_TO_DIS_RST;
            lc2_reg <= PLCR_LC2_RST;
        end else begin
            to_dis_reg <= to_dis_next;
            lc2_reg <= lc2_next;
        end
    end

    // read path: one cycle answer
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    always_comb begin
        rvalid_next = cfg_rd;
        rdata_next = PLCR_UNMAPPED;
        if (cfg_rd) begin
            case (dword_of(cfg_addr))
                dword_of(PLCR_OFF_LINK_STATE): begin
                    rdata_next = {link_state_report, 16'h0000};
                end
                dword_of(PLCR_OFF_DEV_CAPS2): begin
                    rdata_next = device_caps_second;
                end
                dword_of(PLCR_OFF_DEV_CTRL2): begin
                    rdata_next = {16'h0000, device_control_second};
                end
                dword_of(PLCR_OFF_LINK_CTRL2): begin
                    rdata_next = {link_state_report_second,
                                  link_control_second};
                end
                default: begin
                    rdata_next = PLCR_UNMAPPED;
                end
            endcase
        end
    end

    // outputs toward the link logic
    logic [11:0] ctl_reg;
    logic [11:0] ctl_next;

    always_comb begin
        ctl_next = {to_dis_next,
                    lc2_next[PLCR_LC2_COMP_EMPH],
                    lc2_next[PLCR_LC2_COMP_SOS],
                    lc2_next[PLCR_LC2_MOD_COMP],
                    lc2_next[PLCR_LC2_MARGIN_HI:PLCR_LC2_MARGIN_LO],
                    lc2_next[PLCR_LC2_COMP_ENTRY],
                    lc2_next[3:0]};
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= PLCR_UNMAPPED;
            rvalid_reg <= 1'h0;
            ctl_reg <= 12'h000;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            ctl_reg <= ctl_next;
        end
    end

    assign cfg_rdata = rdata_reg;
    assign cfg_rvalid = rvalid_reg;
    assign timeout_disable = ctl_reg[11];
    assign compliance_emphasis = ctl_reg[10];
    assign compliance_skip_ordered_set = ctl_reg[9];
    assign modified_compliance_entry = ctl_reg[8];
    assign transmit_margin = ctl_reg[7:5];
    assign compliance_entry = ctl_reg[4];
    assign target_speed = ctl_reg[3:0];
endmodule

// ==== testbench/plcr_link_model.sv ====
`timescale 1ns/1ps
module plcr_link_model
    import plcr_pkg::*;
(
    // clock
    input wire logic mclk,
    // commanded link state
    input wire logic [3:0] speed_cmd,
    input wire logic emph_cmd,
    // toward the register bank
    output logic [3:0] current_speed,
    output logic emphasis_level_now
);
    // link state moves away from the register clock edge
    always @(negedge mclk) begin
        current_speed <= speed_cmd;
        emphasis_level_now <= emph_cmd;
    end
endmodule

// ==== testbench/plcr_regs_chk.sv ====
`timescale 1ns/1ps
module plcr_regs_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    input wire logic link_reset_n,
    // configuration access
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    // link side
    input wire logic [3:0] current_speed,
    input wire logic emphasis_level_now,
    input wire logic timeout_disable,
    input wire logic [2:0] transmit_margin,
    input wire logic compliance_entry,
    input wire logic [3:0] target_speed
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic [2:0] up_reg, up_next;
    wire td_bit = cfg_wdata[4];
    wire [3:0] ts_bits = cfg_wdata[3:0];
    wire [5:0] dw = cfg_addr[7:2];
    // cycles since reset, saturating
    always_comb begin
        up_next = up_reg;
        if (up_reg != 3'h7) up_next = up_reg + 3'h1;
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) up_reg <= 3'h0;
        else up_reg <= up_next;
    end
    sequence rd_at(logic [5:0] a);
        cfg_rd && dw == a;
    endsequence
    sequence spd_ok;
        $stable(current_speed)[*4] ##0 up_reg == 3'h7;
    endsequence
    sequence emph_ok;
        $stable(emphasis_level_now)[*4] ##0 up_reg == 3'h7;
    endsequence
    chk_lstat_fixed: assert property (rd_at(6'h20) |=>
        cfg_rdata[31:20] == 12'h101 && cfg_rdata[15:0] == 16'h0000)
        else $error("link status fixed bits wrong");
    chk_lstat_speed: assert property (spd_ok ##0 rd_at(6'h20) |=>
        cfg_rdata[19:16] == $past(current_speed))
        else $error("link status speed wrong");
    chk_caps_const: assert property (rd_at(6'h25) |=>
        cfg_rdata == 32'h00000010) else $error("caps2 value wrong");
    chk_ctrl2_read: assert property (rd_at(6'h26) |=>
        cfg_rdata == (32'h00000800 | {27'h0, $past(timeout_disable), 4'h0}))
        else $error("device control 2 read wrong");
    chk_td_write: assert property (link_reset_n[*4] ##0
        (cfg_wr && dw == 6'h26 && cfg_be[0]) |=>
        timeout_disable == $past(td_bit)) else $error("timeout bit lost");
    chk_lc2_write: assert property (cfg_wr && dw == 6'h28 && cfg_be[0]
        |=> target_speed == $past(ts_bits)) else $error("target not set");
    chk_lc2_sticky: assert property (!(cfg_wr && dw == 6'h28) |=>
        $stable({compliance_entry, transmit_margin, target_speed}))
        else $error("link control 2 changed without write");
    chk_ls2_read: assert property (emph_ok ##0 rd_at(6'h28) |=>
        cfg_rdata[31:16] == {15'h0000, $past(emphasis_level_now)} &&
        cfg_rdata[15:13] == 3'h0 && cfg_rdata[6:5] == 2'h0)
        else $error("link status 2 read wrong");
endmodule
bind plcr_regs plcr_regs_chk plcr_regs_chk_inst (.mclk, .resetn,
    .link_reset_n, .cfg_addr, .cfg_rd, .cfg_wr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .current_speed, .emphasis_level_now, .timeout_disable,
    .transmit_margin, .compliance_entry, .target_speed);

// ==== testbench/test_plcr_regs.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module test_plcr_regs
    import plcr_pkg::*;
;
    logic mclk, resetn, link_reset_n, cfg_rd, cfg_wr, cfg_rvalid, emph_cmd;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be, current_speed, target_speed, speed_cmd;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic emphasis_level_now, timeout_disable, compliance_emphasis;
    logic compliance_skip_ordered_set, modified_compliance_entry;
    logic compliance_entry;
    logic [2:0] transmit_margin;
    int err_count = 0;
    int check_count = 0;
    plcr_regs plcr_regs_inst (.mclk, .resetn, .link_reset_n, .cfg_addr,
        .cfg_rd, .cfg_wr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
        .current_speed, .emphasis_level_now, .timeout_disable,
        .compliance_emphasis, .compliance_skip_ordered_set,
        .modified_compliance_entry, .transmit_margin, .compliance_entry,
        .target_speed);
    plcr_link_model plcr_link_model_inst (.mclk, .speed_cmd, .emph_cmd,
        .current_speed, .emphasis_level_now);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic wr(input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, b, d};
        @(negedge mclk);
        cfg_wr = 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge mclk);
        `CHK("rvalid", 1'b1, cfg_rvalid)
        `CHK("rdata", e, cfg_rdata)
        cfg_rd = 1'b0;
        @(negedge mclk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #(25 * 3000);
        err_count++;
        results();
    end
    initial begin
        {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
        {resetn, link_reset_n, emph_cmd, speed_cmd} = {3'b010, PLCR_SPEED_2G5};
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        rd(8'h80, 32'h10110000);
        rd(8'h94, 32'h00000010);
        rd(8'h98, 32'h00000800);
        rd(8'hA0, 32'h00000000);
        rd(8'h84, 32'h00000000);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            speed_cmd = i[1] ? PLCR_SPEED_5G : PLCR_SPEED_2G5;
            emph_cmd = i[0];
            repeat (6) @(negedge mclk);
            rd(8'h80, {12'h101, speed_cmd, 16'h0000});
            rd(8'hA0, {15'h0000, emph_cmd, 16'h0000});
        end
        $display("test live status done");
        wr(8'h80, 4'hF, 32'hFFFFFFFF);
        rd(8'h80, {12'h101, speed_cmd, 16'h0000});
        wr(8'h94, 4'hF, 32'hFFFFFFFF);
        rd(8'h94, 32'h00000010);
        wr(8'h98, 4'hF, 32'hFFFFFFFF);
        rd(8'h98, 32'h00000810);
        `CHK("timeout_disable", 1'b1, timeout_disable)
        wr(8'hA0, 4'h3, 32'hFFFFFFFF);
        rd(8'hA0, {15'h0000, emph_cmd, 16'h1F9F});
        `CHK("target_speed", 4'hF, target_speed)
        `CHK("compliance_emphasis", 1'b1, compliance_emphasis)
        `CHK("skip_ordered_set", 1'b1, compliance_skip_ordered_set)
        `CHK("modified_entry", 1'b1, modified_compliance_entry)
        `CHK("transmit_margin", 3'h7, transmit_margin)
        `CHK("compliance_entry", 1'b1, compliance_entry)
        wr(8'hA0, 4'h1, 32'h00000000);
        rd(8'hA0, {15'h0000, emph_cmd, 16'h1F00});
        `CHK("transmit_margin", 3'h6, transmit_margin)
        `CHK("target_speed", 4'h0, target_speed)
        $display("test writes done");
        link_reset_n = 1'b0;
        repeat (5) @(negedge mclk);
        link_reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        rd(8'hA0, {15'h0000, emph_cmd, 16'h1F00});
        rd(8'h98, 32'h00000800);
        `CHK("timeout_disable", 1'b0, timeout_disable)
        `CHK("compliance_emphasis", 1'b1, compliance_emphasis)
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        rd(8'hA0, {15'h0000, emph_cmd, 16'h0000});
        `CHK("compliance_emphasis", 1'b0, compliance_emphasis)
        $display("test resets done");
        results();
    end
endmodule
